// File: verilog/bbg_gating.sv
// Supply switchover mode control with serial bus gating.
// Assumes comparator inputs are already synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "bbg_defs.svh"

module bbg_gating
   import bbg_pkg::*;
(
   input wire logic ref_clk_i,          // 250 MHz clock.
   input wire logic resetn_i,           // Synchronous reset, active low.
   input wire logic sel_we_i,           // Write strobe for mode bits.
   input wire logic bus_in_backup_select_i,   // New bus-in-backup bit.
   input wire logic switchover_mode_select_i, // New switch-mode bit.
   input wire bbg_cmp_s cmp_i,          // Supply comparator levels.
   input wire bbg_bus_s bus_i,          // Sampled serial bus lines.
   input wire logic alarm_req_i,        // Alarm/frequency drive request.
   output logic on_backup_o,            // Running from backup supply.
   output logic bus_en_o,               // Serial bus may answer.
   output logic eeprom_en_o,            // EEPROM usable.
   output logic low_voltage_reset_o,    // Reset asserted, main below level.
   output logic func_en_o,              // Non-timekeeping functions on.
   output logic legacy_o,               // Legacy switchover selected.
   output logic alarm_irq_freq_out_o    // Alarm/frequency pin drive.
);
   // ========================================================================
   // Mode bits, held in flip-flops; power-up picks standard mode.
   logic bus_sel_reg;
   logic sw_sel_reg;
   bbg_src_e src_reg;
   bbg_src_e src_next;
   logic alarm_reg;

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         bus_sel_reg <= `BBG_SEL_RESET;
         sw_sel_reg <= `BBG_SEL_RESET;                   // [R01]
      end else if (sel_we_i) begin
         bus_sel_reg <= bus_in_backup_select_i;
         sw_sel_reg <= switchover_mode_select_i;
      end
   end

   // ========================================================================
   // Switchover decision. Standard mode ignores the bus bit entirely, so
   // modes 1/0 and 0/0 share one path.
   wire legacy = sw_sel_reg;
   wire std_fall = ~cmp_i.main_above_trip;                 // [R03] [R05]
   // Legacy runs from backup only when backup beats main and the trip level.
   wire leg_fall = ~cmp_i.main_above_backup &
                   cmp_i.backup_above_trip;                // [R04] [R06] [R08]
   wire go_backup = legacy ? leg_fall : std_fall;
   assign src_next = go_backup ? BBG_ON_BACKUP : BBG_ON_MAIN;

   // ========================================================================
   // Bus permission by mode. A main supply below reset always blocks it.
   wire mode_b = ~bus_sel_reg & sw_sel_reg;
   wire mode_d = bus_sel_reg & sw_sel_reg;
   wire allow_std = cmp_i.main_above_reset & ~go_backup;   // [R03] [R05]
   wire allow_b = cmp_i.main_above_reset;                  // [R04]
   wire allow_d = cmp_i.main_above_reset &
                  cmp_i.main_above_backup & ~go_backup;    // [R06]
   wire bus_allow = mode_b ? allow_b : (mode_d ? allow_d : allow_std);

   // Restart filter: the bus only wakes on a fresh start condition.
   bbg_start_gate u_gate (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .allow_i(bus_allow),
      .bus_i(bus_i),
      .bus_en_o(bus_en_o)
   );

   // Source and alarm pin registers; the pin never depends on mode.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         src_reg <= BBG_ON_MAIN;
         alarm_reg <= 1'B0;
      end else begin
         src_reg <= src_next;
         alarm_reg <= alarm_req_i;                       // [R07]
      end
   end

   // ========================================================================
   // Output decode. EEPROM follows the bus only in mode 0/1 during backup.
   assign on_backup_o = (src_reg == BBG_ON_BACKUP);
   assign eeprom_en_o = bus_en_o & (~on_backup_o | mode_b);  // [R04]
   assign low_voltage_reset_o = ~cmp_i.main_above_reset;     // [R02]
   // Standard backup leaves only timekeeping and the alarm pin alive.
   assign func_en_o = ~on_backup_o | legacy;                  // [R09] [R08]
   assign legacy_o = legacy;
   assign alarm_irq_freq_out_o = alarm_reg;

   // ========================================================================
   // Checks.
   property p_reset_level_blocks;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      !cmp_i.main_above_reset |-> !bus_en_o;
   endproperty
   a_reset_level_blocks: assert property (p_reset_level_blocks) // [R02]
      else $error("Bus active below reset level.");

   property p_reset_std;
      @(posedge ref_clk_i) $rose(resetn_i) |-> !legacy_o;
   endproperty
   a_reset_std: assert property (p_reset_std) // [R01]
      else $error("Not standard mode after reset.");

   property p_std_trip;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (!legacy_o && !cmp_i.main_above_trip && !sel_we_i) |=> on_backup_o;
   endproperty
   a_std_trip: assert property (p_std_trip) // [R03]
      else $error("Standard mode missed trip switchover.");

   property p_c_like_a;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (!legacy_o && on_backup_o) |-> !bus_en_o && !eeprom_en_o;
   endproperty
   a_c_like_a: assert property (p_c_like_a) // [R05]
      else $error("Bus alive in standard backup.");

   property p_leg_switch;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (legacy_o && !sel_we_i && !cmp_i.main_above_backup &&
       cmp_i.backup_above_trip) |=> on_backup_o;
   endproperty
   a_leg_switch: assert property (p_leg_switch) // [R04]
      else $error("Legacy mode missed backup switchover.");

   property p_d_never;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (mode_d && !cmp_i.main_above_backup) |-> !bus_en_o;
   endproperty
   a_d_never: assert property (p_d_never) // [R06]
      else $error("Mode 1/1 bus active under backup supply.");

   property p_alarm_follow;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      alarm_req_i |=> alarm_irq_freq_out_o;
   endproperty
   a_alarm_follow: assert property (p_alarm_follow) // [R07]
      else $error("Alarm pin did not follow request.");

   property p_std_funcs;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (on_backup_o && !legacy_o) |-> !func_en_o;
   endproperty
   a_std_funcs: assert property (p_std_funcs) // [R09]
      else $error("Functions alive in standard backup.");

   property p_leg_funcs;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      legacy_o |-> func_en_o;
   endproperty
   a_leg_funcs: assert property (p_leg_funcs) // [R08]
      else $error("Legacy mode lost functions.");

   // ========================================================================
   // Switchover must not fire early: a healthy main keeps the chip on it.
   property p_std_holds_main;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (!legacy_o && !sel_we_i && cmp_i.main_above_trip) |=> !on_backup_o;
   endproperty
   a_std_holds_main: assert property (p_std_holds_main) // [R03]
      else $error("Standard mode left main above trip level.");

   // Legacy mode compares the supplies, so a low trip level is not enough.
   property p_leg_holds_main;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (legacy_o && !sel_we_i && cmp_i.main_above_backup) |=> !on_backup_o;
   endproperty
   a_leg_holds_main: assert property (p_leg_holds_main) // [R08]
      else $error("Legacy mode left main above backup supply.");

   // The pin copies the request one cycle late, on both levels.
   property p_alarm_level;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> alarm_irq_freq_out_o == $past(alarm_req_i);
   endproperty
   a_alarm_level: assert property (p_alarm_level) // [R07]
      else $error("Alarm pin differs from last request.");

   // EEPROM rides on the bus, and in backup only mode 0/1 keeps it.
   property p_ee_needs_bus;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      eeprom_en_o |-> bus_en_o;
   endproperty
   a_ee_needs_bus: assert property (p_ee_needs_bus) // [R03]
      else $error("EEPROM usable while bus is off.");

   property p_ee_backup_mode;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (on_backup_o && eeprom_en_o) |-> mode_b;
   endproperty
   a_ee_backup_mode: assert property (p_ee_backup_mode) // [R04]
      else $error("EEPROM usable in backup outside mode 0/1.");

   // ========================================================================
   // Restart filter, seen from the pins. A start needs both lines high, then
   // data falling with the clock still high; the filter answers a cycle later.
   sequence s_fresh_start;
      (bus_allow && bus_i.scl && bus_i.sda) ##1
      (bus_allow && bus_i.scl && !bus_i.sda);
   endsequence

   // A refusal, then the supplies permit traffic again.
   sequence s_refused_then_allowed;
      !bus_allow ##1 bus_allow;
   endsequence

   property p_start_arms;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      s_fresh_start ##1 bus_allow |-> bus_en_o;
   endproperty
   a_start_arms: assert property (p_start_arms) // [R10]
      else $error("Fresh start did not re-enable the bus.");

   // Permission alone never wakes the bus, as it could land mid-transfer.
   property p_refusal_holds;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      s_refused_then_allowed |-> !bus_en_o;
   endproperty
   a_refusal_holds: assert property (p_refusal_holds) // [R10]
      else $error("Bus woke without a start after a refusal.");
endmodule : bbg_gating // bbg_gating
`default_nettype wire

// File: verilog/bbg_defs.svh
// Constants for the battery backup bus gating block.
// Assumes it is included by bare name from the package and the modules.
// What this block does
// (R01) After power-up the mode is standard: switchover at the fixed trip level.
// (R02) Serial bus stops whenever main supply is below the low-voltage reset level.
// (R03) Bits 0/0: trip-level switchover, no bus or EEPROM in backup, alarm pin on.
// (R04) Bits 0/1: switch when main below backup; bus ok if backup>main>reset.
// (R05) Bits 1/0: behave exactly as bits 0/0.
// (R06) Bits 1/1: switch when main below backup; bus only above max(reset,backup).
// (R07) Alarm/frequency output keeps working in backup in all four modes.
// (R08) Legacy modes run chip and alarms from backup above main and trip level.
// (R09) Standard mode in backup disables all but timekeeping and alarm output.
// (R10) After bus re-enable, ignore traffic until a fresh start condition.
`ifndef BBG_DEFS_SVH
`define BBG_DEFS_SVH

// ==========================================================================
// Mode select encodings and reset values.
`define BBG_SEL_RESET 1'B0
`define BBG_MODE_W 2
`define BBG_BUS_BIT 1
`define BBG_SW_BIT 0

`endif

// File: verilog/bbg_pkg.sv
// Types for the battery backup bus gating block.
// Assumes the defines header sits on the include path.
`include "bbg_defs.svh"

package bbg_pkg;
   // Comparator outputs from the analog supply monitors.
   typedef struct packed {
      logic main_above_reset;  // Main supply above reset level.
      logic main_above_trip;   // Main supply above trip level.
      logic main_above_backup; // Main supply above backup supply.
      logic backup_above_trip; // Backup supply above trip level.
   } bbg_cmp_s;

   // Serial bus line samples.
   typedef struct packed {
      logic scl;  // Clock line level.
      logic sda;  // Data line level.
   } bbg_bus_s;

   // Supply source state.
   typedef enum logic [1:0] {
      BBG_ON_MAIN   = 2'B00,
      BBG_ON_BACKUP = 2'B01
   } bbg_src_e;
endpackage : bbg_pkg

// File: verilog/bbg_start_gate.sv
// Start-condition gate that re-arms serial bus traffic after a disable.
// Assumes bus lines are synchronous samples at ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "bbg_defs.svh"

module bbg_start_gate
   import bbg_pkg::*;
(
   input wire logic ref_clk_i,   // 250 MHz clock.
   input wire logic resetn_i,    // Synchronous reset, active low.
   input wire logic allow_i,     // Supply conditions permit traffic.
   input wire bbg_bus_s bus_i,   // Sampled bus lines.
   output logic bus_en_o         // Traffic may be answered.
);
   // ========================================================================
   // Start detection.
   bbg_bus_s bus_reg;
   logic armed_reg;
   logic armed_next;
   wire start_seen = bus_reg.sda & ~bus_i.sda & bus_i.scl & bus_reg.scl;

   // Once disabled, hold off until a start; a half-seen transfer is dropped.
   assign armed_next = ~allow_i ? 1'B0 :
                       (start_seen ? 1'B1 : armed_reg);  // [R10]
   assign bus_en_o = armed_reg & allow_i;                // [R02]

   // State update.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         bus_reg <= '1;
         armed_reg <= 1'B0;
      end else begin
         bus_reg <= bus_i;
         armed_reg <= armed_next;
      end
   end

   // Traffic never enabled without a start since the last disable.
   property p_no_mid_transfer;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      $rose(bus_en_o) |-> $past(start_seen);
   endproperty
   a_no_mid_transfer: assert property (p_no_mid_transfer) // [R10]
      else $error("Bus enabled without a start condition.");
endmodule : bbg_start_gate // bbg_start_gate
`default_nettype wire

// File: test/bbg_host_model.sv
// Host bus master model that drives the sampled serial bus lines.
// Assumes the lines idle high through pull-ups and move on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module bbg_host_model
   import bbg_pkg::*;
(
   input wire logic ref_clk_i, // Bench clock.
   output bbg_bus_s bus_o      // Bus lines seen by the block.
);
   // ==========================================================
   // Line steps: released lines float to the pull-up level.
   initial bus_o = 2'B11;
   task automatic put(input logic scl, input logic sda);
      @(posedge ref_clk_i);
      bus_o <= {scl, sda};
   endtask
   // Data changes only while the clock line is low, so no start.
   task automatic send_bits();
      put(0, 1); put(0, 0); put(1, 0); put(0, 0); put(0, 1); put(1, 1);
   endtask
   // Data falls while the clock line is high: a fresh start.
   task automatic send_start();
      put(1, 1); put(1, 0); put(0, 0); put(0, 1); put(1, 1);
   endtask
endmodule // bbg_host_model

`default_nettype wire

// File: test/test_battery_backup_bus_gating.sv
// Self-checking bench for the supply switchover and bus gating block.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_fail++; \
 $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end

module test_battery_backup_bus_gating
   import bbg_pkg::*;
;
   logic ref_clk_i = 0, resetn_i = 0, sel_we_i = 0, bib = 0, sms = 0;
   logic alarm_req_i = 0, on_b, bus_en, ee_en, lv_rst, func_en, leg, alm;
   bbg_cmp_s cmp_i = 4'B1111;
   bbg_bus_s bus_w;
   int n_fail = 0, compares = 0, cycles = 0;

   // ==========================================================
   // Clock, watchdog and instances.
   always #2 ref_clk_i = ~ref_clk_i;
   // The ceiling leaves well over twenty times the expected run length.
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         finish_test();
      end
   end
   bbg_host_model host_u (.ref_clk_i(ref_clk_i), .bus_o(bus_w));
   bbg_gating dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .sel_we_i(sel_we_i), .bus_in_backup_select_i(bib),
      .switchover_mode_select_i(sms), .cmp_i(cmp_i), .bus_i(bus_w),
      .alarm_req_i(alarm_req_i), .on_backup_o(on_b), .bus_en_o(bus_en),
      .eeprom_en_o(ee_en), .low_voltage_reset_o(lv_rst), .func_en_o(func_en),
      .legacy_o(leg), .alarm_irq_freq_out_o(alm));

   // ==========================================================
   // Helpers: inputs move by non-blocking assignment at the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic set_cmp(input bbg_cmp_s v, input logic a);
      @(posedge ref_clk_i);
      cmp_i <= v;
      alarm_req_i <= a;
      #1;
   endtask
   task automatic set_mode(input logic b, input logic s);
      @(posedge ref_clk_i);
      {sel_we_i, bib, sms} <= {1'B1, b, s};
      @(posedge ref_clk_i);
      sel_we_i <= 0;
      #1;
   endtask

   // ==========================================================
   // Scenarios.
   task automatic t_power_up();
      `CHK("legacy", 1'B0, leg)
      `CHK("bus_en", 1'B0, bus_en)
      set_mode(1, 1);
      @(posedge ref_clk_i);
      resetn_i <= 0;
      @(posedge ref_clk_i);
      resetn_i <= 1;
      #1;
      `CHK("legacy_rst", 1'B0, leg)
   endtask
   // Traffic without a start stays ignored; a start arms the bus.
   task automatic t_start_gate();
      host_u.send_bits();
      tick(2);
      `CHK("bits_only", 1'B0, bus_en)
      host_u.send_start();
      tick(2);
      `CHK("after_start", 1'B1, bus_en)
   endtask
   // Main below reset level cuts the bus in the same cycle.
   task automatic t_low_reset();
      set_cmp(4'B0111, 0);
      `CHK("low_reset", 1'B1, lv_rst)
      `CHK("bus_low_reset", 1'B0, bus_en)
      set_cmp(4'B1111, 0);
      tick(2);
      `CHK("no_rearm", 1'B0, bus_en)
   endtask
   // Every mode: main between backup and reset, then deep backup.
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         set_mode(m[1], m[0]);
         `CHK("legacy_mode", m[0], leg)
         set_cmp(4'B1101, 0);
         host_u.send_start();
         tick(2);
         `CHK("src_mid", m[0], on_b)
         `CHK("ee_mid", !(m[1] && m[0]), ee_en)
         `CHK("bus_mid", !(m[1] && m[0]), bus_en)
         set_cmp(4'B0001, 1);
         tick(1);
         `CHK("src_deep", 1'B1, on_b)
         `CHK("bus_deep", 1'B0, bus_en)
         `CHK("func_deep", m[0], func_en)
         `CHK("alarm_on", 1'B1, alm)
         set_cmp(4'B0001, 0);
         tick(1);
         `CHK("alarm_off", 1'B0, alm)
         set_cmp(4'B1111, 0);
         tick(1);
         `CHK("src_main", 1'B0, on_b)
      end
   endtask

   // ==========================================================
   // Verdict and main sequence.
   task automatic finish_test();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      resetn_i <= 1;
      #1;
      t_power_up();
      t_start_gate();
      t_low_reset();
      t_modes();
      finish_test();
   end
endmodule // test_battery_backup_bus_gating

`default_nettype wire
